// ==== gpsf_gpio.sv ====
/*
 * Four-pin GPIO block with two shared functions, behind one 32-bit
 * control register on an AXI4-Lite slave port.
 * Assumes one clock, a synchronous active-high reset, pin inputs that
 * come from the board (synchronised here) and function inputs that
 * come from link logic on the same clock.
 * Terminal drive follows a register write by one clock; the sensed
 * level trails the terminal by three clocks through the synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none

module gpsf_gpio
   import gpsf_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic [ADDR_W-1:0]    awaddr,
   input  wire logic [2:0]           awprot,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   input  wire logic [ADDR_W-1:0]    araddr,
   input  wire logic [2:0]           arprot,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready,
   input  wire logic                 manager_contender_flag,
   input  wire logic                 link_power_indicator,
   input  wire logic [PIN_COUNT-1:0] pin_in,
   output logic [PIN_COUNT-1:0]      pin_out,
   output logic [PIN_COUNT-1:0]      pin_oe,
   output logic [PIN_COUNT-1:0]      pin_sense
);

   // True when a byte address selects the control register
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a == ADDR_W'(GPIO_CONTROL_OFFSET));
   endfunction

   // Widen byte strobes to a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   logic [31:0]          ctrl;        // The control register
   logic                 aw_held;     // Write address waiting
   logic [ADDR_W-1:0]    aw_addr_q;   // Held write address
   logic                 w_held;      // Write data waiting
   logic [31:0]          w_data_q;    // Held write data
   logic [3:0]           w_strb_q;    // Held write strobes
   logic                 do_write;    // Both halves present, no reply pending
   logic [31:0]          next_ctrl;   // Control value after a write
   logic [PIN_COUNT-1:0] sync1;       // First synchroniser stage
   logic [PIN_COUNT-1:0] sync2;       // Second synchroniser stage
   logic [PIN_COUNT-1:0] gpio_val;    // Per-pin GPIO drive level
   logic [PIN_COUNT-1:0] gpio_en;     // Per-pin GPIO drive enable
   logic [PIN_COUNT-1:0] flip_eff;    // Polarity that applies now
   logic [PIN_COUNT-1:0] next_pin_out;
   logic [PIN_COUNT-1:0] next_pin_oe;

   // Protection bits are accepted and ignored
   logic unused_prot;
   assign unused_prot = ^{awprot, arprot};

   assign do_write = aw_held && w_held && !bvalid;

   // Write merge: only writable bits in enabled lanes change
   always_comb begin
      logic [31:0] m;
      m = GPIO_CONTROL_WMASK & strb_mask(w_strb_q);
      next_ctrl = (ctrl & ~m) | (w_data_q & m);
   end

   // Write address channel; one address held at a time
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held   <= 1'b0;
         aw_addr_q <= '0;
         awready   <= 1'b0;
      end else if (awvalid && awready) begin
         aw_held   <= 1'b1;
         aw_addr_q <= awaddr;
         awready   <= 1'b0;
      end else if (do_write) begin
         aw_held   <= 1'b0;
      end else if (!aw_held && !bvalid) begin
         awready   <= 1'b1;  // Reopen only after the reply is taken
      end
   end

   // Write data channel; taken independently of the address
   always_ff @(posedge clk) begin
      if (rst) begin
         w_held   <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         wready   <= 1'b0;
      end else if (wvalid && wready) begin
         w_held   <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
         wready   <= 1'b0;
      end else if (do_write) begin
         w_held   <= 1'b0;
      end else if (!w_held && !bvalid) begin
         wready   <= 1'b1;
      end
   end

   // Write response; unmapped addresses answer with an error
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= addr_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Control register; reset leaves both shared functions in place
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= GPIO_CONTROL_RESET;
      end else if (do_write && addr_hit(aw_addr_q)) begin
         ctrl <= next_ctrl;
      end
   end

   // Read channel; one read in flight, data from stored bits
   always_ff @(posedge clk) begin
      if (rst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         if (addr_hit(araddr)) begin
            rdata <= ctrl;
            rresp <= RESP_OKAY;
         end else begin
            rdata <= '0;
            rresp <= RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // Per-pin GPIO levels after output inversion
   always_comb begin
      gpio_val[3] = ctrl[PIN3_LEVEL] ^ ctrl[PIN3_POLARITY_FLIP];
      gpio_val[2] = ctrl[PIN2_LEVEL] ^ ctrl[PIN2_POLARITY_FLIP];
      gpio_val[1] = ctrl[PIN1_LEVEL] ^ ctrl[PIN1_POLARITY_FLIP];
      gpio_val[0] = ctrl[PIN0_LEVEL] ^ ctrl[PIN0_POLARITY_FLIP];
      gpio_en[3]  = ctrl[PIN3_DRIVE_ON];
      gpio_en[2]  = ctrl[PIN2_DRIVE_ON];
      gpio_en[1]  = ctrl[PIN1_DRIVE_ON];
      gpio_en[0]  = ctrl[PIN0_DRIVE_ON];
   end

   // Terminal mux: shared functions own pins 0 and 1 until released
   // Function mode drives the raw link signal; polarity bits do not apply
   always_comb begin
      next_pin_out = gpio_val;
      next_pin_oe  = gpio_en;
      if (!ctrl[CONTENDER_RELEASE]) begin
         next_pin_out[0] = manager_contender_flag;
         next_pin_oe[0]  = 1'b1;
      end else begin
         next_pin_oe[0]  = gpio_en[0];
      end
      if (!ctrl[POWER_STATUS_RELEASE]) begin
         next_pin_out[1] = link_power_indicator;
         next_pin_oe[1]  = 1'b1;
      end else begin
         next_pin_oe[1]  = gpio_en[1];
      end
   end

   // Registered terminal drive, one cycle behind the register
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out <= '0;
         pin_oe  <= '0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe  <= next_pin_oe;
      end
   end

   // Two-stage synchroniser; the board pins are asynchronous
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
      end
   end

   // Input inversion applies to pins 0 and 1 only in GPIO mode
   always_comb begin
      flip_eff[3] = ctrl[PIN3_POLARITY_FLIP];
      flip_eff[2] = ctrl[PIN2_POLARITY_FLIP];
      flip_eff[1] = ctrl[PIN1_POLARITY_FLIP] & ctrl[POWER_STATUS_RELEASE];
      flip_eff[0] = ctrl[PIN0_POLARITY_FLIP] & ctrl[CONTENDER_RELEASE];
   end

   // Sensed terminal level in the logical sense
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_sense <= '0;
      end else begin
         pin_sense <= sync2 ^ flip_eff;
      end
   end

   // Checks on the behaviour guarded above

   chk_reset_funcs: assert property (@(posedge clk)
      $past(rst) && !rst |-> ctrl == GPIO_CONTROL_RESET)
      else $error("Reset did not restore control value");

   // The !rst term skips the edge on which reset is released: the
   // terminal drive is still being cleared by that edge
   chk_pin0_func: assert property (@(posedge clk) disable iff (rst)
      !rst && !ctrl[CONTENDER_RELEASE] |=>
         pin_oe[0] && pin_out[0] == $past(manager_contender_flag))
      else $error("Terminal 0 not carrying contender flag");

   chk_pin1_func: assert property (@(posedge clk) disable iff (rst)
      !rst && !ctrl[POWER_STATUS_RELEASE] |=>
         pin_oe[1] && pin_out[1] == $past(link_power_indicator))
      else $error("Terminal 1 not carrying power status");

   chk_pin3_drive: assert property (@(posedge clk) disable iff (rst)
      ctrl[PIN3_DRIVE_ON] |=> pin_oe[3] &&
         pin_out[3] == $past(ctrl[PIN3_LEVEL] ^ ctrl[PIN3_POLARITY_FLIP]))
      else $error("GPIO3 drive level wrong");

   chk_pin3_release: assert property (@(posedge clk) disable iff (rst)
      !ctrl[PIN3_DRIVE_ON] |=> !pin_oe[3])
      else $error("GPIO3 driven while disabled");

   chk_pin2_drive: assert property (@(posedge clk) disable iff (rst)
      ctrl[PIN2_DRIVE_ON] |=> pin_oe[2] &&
         pin_out[2] == $past(ctrl[PIN2_LEVEL] ^ ctrl[PIN2_POLARITY_FLIP]))
      else $error("GPIO2 drive level wrong");

   chk_pin2_release: assert property (@(posedge clk) disable iff (rst)
      !ctrl[PIN2_DRIVE_ON] |=> !pin_oe[2])
      else $error("GPIO2 driven while disabled");

   chk_pin1_gpio: assert property (@(posedge clk) disable iff (rst)
      ctrl[POWER_STATUS_RELEASE] |=> pin_oe[1] == $past(ctrl[PIN1_DRIVE_ON]))
      else $error("GPIO1 enable not followed");

   chk_pin1_level: assert property (@(posedge clk) disable iff (rst)
      ctrl[POWER_STATUS_RELEASE] && ctrl[PIN1_DRIVE_ON] |=>
         pin_out[1] == $past(ctrl[PIN1_LEVEL] ^ ctrl[PIN1_POLARITY_FLIP]))
      else $error("GPIO1 drive level wrong");

   chk_pin0_gpio: assert property (@(posedge clk) disable iff (rst)
      ctrl[CONTENDER_RELEASE] |=> pin_oe[0] == $past(ctrl[PIN0_DRIVE_ON]))
      else $error("GPIO0 enable not followed");

   chk_pin0_level: assert property (@(posedge clk) disable iff (rst)
      ctrl[CONTENDER_RELEASE] && ctrl[PIN0_DRIVE_ON] |=>
         pin_out[0] == $past(ctrl[PIN0_LEVEL] ^ ctrl[PIN0_POLARITY_FLIP]))
      else $error("GPIO0 drive level wrong");

   chk_sense_flip: assert property (@(posedge clk) disable iff (rst)
      !ctrl[POWER_STATUS_RELEASE] |=> pin_sense[1] == $past(sync2[1]))
      else $error("GPIO1 inverted outside GPIO mode");

   chk_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
      (ctrl & ~GPIO_CONTROL_WMASK) == 32'h00000000)
      else $error("Reserved control bits not zero");

   chk_read_back: assert property (@(posedge clk) disable iff (rst)
      arvalid && arready && addr_hit(araddr) |=>
         rvalid && rdata == $past(ctrl) && rresp == RESP_OKAY)
      else $error("Read data differs from stored value");

   // Sense path: synchroniser output, flipped only where the pin is GPIO
   chk_sense_pin0: assert property (@(posedge clk) disable iff (rst)
      !ctrl[CONTENDER_RELEASE] |=> pin_sense[0] == $past(sync2[0]))
      else $error("GPIO0 inverted outside GPIO mode");

   chk_sense_pin2: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> pin_sense[2] == $past(sync2[2] ^ ctrl[PIN2_POLARITY_FLIP]))
      else $error("GPIO2 sensed level wrong");

   chk_sense_pin3: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> pin_sense[3] == $past(sync2[3] ^ ctrl[PIN3_POLARITY_FLIP]))
      else $error("GPIO3 sensed level wrong");

   chk_reset_quiet: assert property (@(posedge clk)
      rst |=> pin_oe == '0 && !bvalid && !rvalid)
      else $error("Outputs active after a reset edge");

endmodule

`default_nettype wire

// ==== gpsf_pkg.sv ====
/*
 * Constants for the four-pin GPIO block: the control register's offset,
 * its field positions, its reset value and the mask of its writable bits.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
`default_nettype none

package gpsf_pkg;

   // Register map
   localparam logic [7:0]  GPIO_CONTROL_OFFSET = 8'hFC;  // Byte address
   localparam logic [31:0] GPIO_CONTROL_RESET  = 32'h00001010;

   // Field positions inside the control register
   localparam int PIN0_LEVEL          = 0;
   localparam int PIN0_DRIVE_ON       = 4;
   localparam int PIN0_POLARITY_FLIP  = 5;
   localparam int CONTENDER_RELEASE   = 7;
   localparam int PIN1_LEVEL          = 8;
   localparam int PIN1_DRIVE_ON       = 12;
   localparam int PIN1_POLARITY_FLIP  = 13;
   localparam int POWER_STATUS_RELEASE = 15;
   localparam int PIN2_LEVEL          = 16;
   localparam int PIN2_DRIVE_ON       = 20;
   localparam int PIN2_POLARITY_FLIP  = 21;
   localparam int PIN3_LEVEL          = 24;
   localparam int PIN3_DRIVE_ON       = 28;
   localparam int PIN3_POLARITY_FLIP  = 29;

   // Bits that software may change; all others read as zero
   localparam logic [31:0] GPIO_CONTROL_WMASK = 32'h3131B1B1;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Number of terminals
   localparam int PIN_COUNT = 4;

endpackage

`default_nettype wire

// ==== gpsf_board.sv ====
/*
 * Board model for the four GPIO terminals.
 * Assumes the block drives pin_out where pin_oe is high; on a released
 * terminal the board's own driver sets the level from board_level.
 */
`timescale 1ns/1ps
`default_nettype none

module gpsf_board (
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] board_level,
   output logic [3:0]      pin_in
);
   // Resolve each terminal: the block wins while it drives, else the board
   // Never leaves a stale copy of the block's last value on a released pin
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : board_level[i];
      end
   end
endmodule

`default_nettype wire

// ==== test_four_pin_gpio_with_shared_functions.sv ====
/*
 * Self-checking bench for the four-pin GPIO block.
 * Assumes a 200 MHz clock, synchronous reset, AXI4-Lite register access.
 */
`timescale 1ns/1ps
`default_nettype none

module test_four_pin_gpio_with_shared_functions
   import gpsf_pkg::*;
;
   logic        clk, rst;                    // Clock and reset
   logic [7:0]  awaddr, araddr;              // Bus addresses
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;                // Bus data
   logic [3:0]  wstrb;                       // Byte lanes
   logic [1:0]  bresp, rresp;                // Responses
   logic        contender_in, power_status_in;  // Function inputs
   logic [3:0]  pin_in, pin_out, pin_oe, pin_sense, board_level;
   int          n_mismatch = 0;
   int          comparisons = 0;

   gpsf_gpio dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .manager_contender_flag(contender_in),
      .link_power_indicator(power_status_in),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_sense(pin_sense));

   gpsf_board board (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board_level),
      .pin_in(pin_in));

   // Free-running 5 ns clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Offer address and data together; release each when taken
   // One idle edge closes each call, so back-to-back calls never assign
   // a strobe twice in one time step
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
      logic aw_open;
      logic w_open;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      aw_open = 1'b1;
      w_open  = 1'b1;
      while (aw_open || w_open) begin
         @(posedge clk);
         if (aw_open && awready) begin
            awvalid <= 1'b0;
            aw_open = 1'b0;
         end
         if (w_open && wready) begin
            wvalid <= 1'b0;
            w_open = 1'b0;
         end
      end
      @(posedge clk);
      while (!bvalid) @(posedge clk);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask

   // Hold the address until taken and rready until the data arrive
   task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      @(posedge clk);
      while (!arready) @(posedge clk);
      arvalid <= 1'b0;
      @(posedge clk);
      while (!rvalid) @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // Write the control word, then let the pins and sense path settle
   task automatic set_ctrl(input logic [31:0] v);
      logic [1:0] r;
      bus_write(GPIO_CONTROL_OFFSET, v, 4'hF, r);
      chk_word({30'h0, r}, {30'h0, RESP_OKAY});
      wait_clk(6);
   endtask

   task automatic expect_ctrl(input logic [31:0] v);
      logic [31:0] d;
      logic [1:0]  r;
      bus_read(GPIO_CONTROL_OFFSET, d, r);
      chk_word(d, v);
   endtask

   // Terminals 0 and 1 carry the functions out of reset, polarity ignored
   task automatic test_reset_functions();
      expect_ctrl(GPIO_CONTROL_RESET);
      chk_word({28'h0, pin_oe}, 32'h3);
      set_ctrl(32'h0000_2020);
      for (int k = 0; k < 4; k++) begin
         contender_in    <= k[0];
         power_status_in <= k[1];
         wait_clk(6);
         chk_bit(pin_out[0], k[0]);
         chk_bit(pin_out[1], k[1]);
         chk_bit(pin_sense[0], k[0]);
         chk_bit(pin_sense[1], k[1]);
      end
   endtask

   // Reserved positions read zero; unmapped address refused; lanes kept
   task automatic test_reserved_and_errors();
      logic [31:0] d;
      logic [1:0]  r;
      set_ctrl(32'hFFFF_FFFF);
      expect_ctrl(GPIO_CONTROL_WMASK);
      bus_write(8'hF8, 32'h0, 4'hF, r);
      chk_word({30'h0, r}, {30'h0, RESP_SLVERR});
      bus_read(8'hF8, d, r);
      chk_word({30'h0, r}, {30'h0, RESP_SLVERR});
      chk_word(d, 32'h0000_0000);
      expect_ctrl(GPIO_CONTROL_WMASK);
      bus_write(GPIO_CONTROL_OFFSET, 32'h0, 4'h1, r);
      expect_ctrl(GPIO_CONTROL_WMASK & 32'hFFFF_FF00);
   endtask

   // Every pin through every enable, flip and data combination
   task automatic test_pin_table();
      int lv[4] = '{PIN0_LEVEL, PIN1_LEVEL, PIN2_LEVEL, PIN3_LEVEL};
      int dr[4] = '{PIN0_DRIVE_ON, PIN1_DRIVE_ON, PIN2_DRIVE_ON, PIN3_DRIVE_ON};
      int fl[4] = '{PIN0_POLARITY_FLIP, PIN1_POLARITY_FLIP, PIN2_POLARITY_FLIP,
                    PIN3_POLARITY_FLIP};
      logic [31:0] v;
      logic        dat, en, fp, lvl;
      for (int p = 0; p < 4; p++) begin
         for (int k = 0; k < 8; k++) begin
            dat = k[0];
            en  = k[1];
            fp  = k[2];
            v = 32'h0000_8080;
            v[lv[p]] = dat;
            v[dr[p]] = en;
            v[fl[p]] = fp;
            // A released terminal shows the inverse of the block's level,
            // so a drive that ignored the enable cannot pass unseen
            board_level <= {4{~(dat ^ fp)}};
            set_ctrl(v);
            expect_ctrl(v);
            lvl = en ? (dat ^ fp) : ~(dat ^ fp);
            chk_bit(pin_oe[p], en);
            if (en) chk_bit(pin_out[p], dat ^ fp);
            chk_bit(pin_sense[p], lvl ^ fp);
         end
      end
   endtask

   // Main sequence: defaults at time zero, 3-cycle reset, then scenarios
   initial begin
      rst             = 1'b1;
      awaddr          = 8'h00;
      araddr          = 8'h00;
      wdata           = 32'h0000_0000;
      wstrb           = 4'h0;
      awvalid         = 1'b0;
      wvalid          = 1'b0;
      bready          = 1'b0;
      arvalid         = 1'b0;
      rready          = 1'b0;
      contender_in    = 1'b0;
      power_status_in = 1'b0;
      board_level     = 4'h0;
      wait_clk(3);
      rst <= 1'b0;
      wait_clk(3);
      test_reset_functions();
      test_reserved_and_errors();
      test_pin_table();
      test_done();
   end

   // Watchdog: the scenarios need well under 10,000 cycles
   initial begin
      #200000;
      n_mismatch++;
      test_done();
   end
endmodule

`default_nettype wire
